// ---- logic/rsi_reset_ctrl.sv ----
// The APB slave port was decided locally.
`timescale 1ns/1ns
// Behaviour
// - pin/supply reset: stack pointer 5, timer/comparator bits set
// - interrupt level bit copies pin at reset
// - stack fault reset: stack pointer 5, rest cleared
// - data memory kept only on standby pin/supply
// - shift register kept only on standby pin/supply
// - window register kept likewise; system registers cleared
// - after pin release: clock, wait, run at 0
// - wait ends after 256 x 256 clocks
// - stack fault reset skips the wait
// - power-down detector acts only when enabled
module rsi_reset_ctrl #(
    parameter int WAIT_CYCLES = rsi_pkg::STAB_CYCLES
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // reset sources
    input  wire logic                    reset_pin_n,
    input  wire logic                    power_on_det,
    input  wire logic                    power_down_det,
    input  wire logic                    stack_fault,
    input  wire logic                    standby,
    input  wire logic                    int_pin,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // core sequencing
    output logic                         core_reset,
    output logic                         sys_clock_run,
    output logic                         init_strobe,
    output logic [rsi_pkg::PC_W-1:0]     program_counter,
    // control register image
    output logic [3:0]                   stack_pointer,
    output logic                         timer_interrupt_request_flag,
    output logic                         timer_run_enable,
    output logic                         comparator_reference_select,
    output logic                         comparator_result_bit,
    output logic                         int_level,
    output logic                         power_down_reset_enable,
    // other units
    output logic                         port_input_mode,
    output logic                         port_latch_clear,
    output logic [7:0]                   timer_count_init,
    output logic                         timer_count_load,
    output logic [7:0]                   timer_modulo,
    output logic                         sysreg_clear,
    output logic                         window_keep,
    output logic                         data_memory_keep,
    output logic                         serial_shift_keep
);

    // ------------------------------------------------------------------
    // reset requests
    // ------------------------------------------------------------------
    logic pdr_en_reg;
    logic supply_req;
    logic level_req;

    // the power-down detector is gated by software
    assign supply_req = power_on_det || (power_down_det && pdr_en_reg);
    assign level_req  = !reset_pin_n || supply_req;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    rsi_pkg::rsi_state_t state_reg;
    rsi_pkg::rsi_state_t state_next;
    logic                wait_done;
    logic                enter_hold;
    logic                enter_init;
    logic                enter_any;

    // level resets win over a stack fault in the same cycle
    assign enter_hold = level_req && (state_reg != rsi_pkg::RSI_HOLD);
    assign enter_init = stack_fault && !level_req
                        && (state_reg == rsi_pkg::RSI_RUN);
    assign enter_any  = enter_hold || enter_init;

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsi_pkg::RSI_RUN: begin
                if (level_req) begin
                    state_next = rsi_pkg::RSI_HOLD;
                end else if (stack_fault) begin
                    state_next = rsi_pkg::RSI_INIT;
                end
            end
            rsi_pkg::RSI_HOLD: begin
                // clock stopped while held; released into the wait
                if (!level_req) begin
                    state_next = rsi_pkg::RSI_WAIT;
                end
            end
            rsi_pkg::RSI_WAIT: begin
                if (level_req) begin
                    state_next = rsi_pkg::RSI_HOLD;
                end else if (wait_done) begin
                    state_next = rsi_pkg::RSI_RUN;
                end
            end
            rsi_pkg::RSI_INIT: begin
                // no stabilisation wait after a stack fault
                state_next = level_req ? rsi_pkg::RSI_HOLD
                                       : rsi_pkg::RSI_RUN;
            end
            default: state_next = rsi_pkg::RSI_HOLD;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= rsi_pkg::RSI_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // wait counter runs only in the wait phase
    rsi_stab_timer #(
        .WAIT_CYCLES (WAIT_CYCLES)
    ) u_stab (
        .clk      (clk),
        .reset_n  (reset_n),
        .count_en (state_reg == rsi_pkg::RSI_WAIT),
        .done     (wait_done)
    );

    // ------------------------------------------------------------------
    // sequencing outputs
    // ------------------------------------------------------------------
    logic core_reset_reg;
    logic clk_run_reg;
    logic strobe_reg;

    // core held until run; clock off only while the request holds
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_reset_reg <= 1'b1;
            clk_run_reg    <= 1'b0;
            strobe_reg     <= 1'b0;
        end else begin
            core_reset_reg <= (state_next != rsi_pkg::RSI_RUN);
            clk_run_reg    <= (state_next != rsi_pkg::RSI_HOLD);
            strobe_reg     <= enter_any;
        end
    end

    // ------------------------------------------------------------------
    // initial states, captured at entry to a reset
    // ------------------------------------------------------------------
    logic       full_init;
    logic       keep_ok;
    logic [3:0] stk_ptr_reg;
    logic       tmr_irq_reg;
    logic       tmr_en_reg;
    logic       cmp_ref_reg;
    logic       cmp_res_reg;
    logic       int_lvl_reg;
    logic       port_clr_reg;
    logic       tcnt_load_reg;
    logic       win_keep_reg;
    logic       dmem_keep_reg;
    logic       sio_keep_reg;
    rsi_pkg::rsi_cause_t cause_reg;

    assign full_init = enter_hold;
    // retention only for a level reset taken in standby
    assign keep_ok   = enter_hold && standby;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stk_ptr_reg   <= rsi_pkg::SP_INIT;
            tmr_irq_reg   <= 1'b1;
            tmr_en_reg    <= 1'b1;
            cmp_ref_reg   <= 1'b1;
            cmp_res_reg   <= 1'b1;
            int_lvl_reg   <= 1'b0;
            port_clr_reg  <= 1'b1;
            tcnt_load_reg <= 1'b1;
            win_keep_reg  <= 1'b0;
            dmem_keep_reg <= 1'b0;
            sio_keep_reg  <= 1'b0;
            cause_reg     <= rsi_pkg::RSI_CAUSE_PWR;
        end else if (enter_any) begin
            stk_ptr_reg   <= rsi_pkg::SP_INIT;
            tmr_irq_reg   <= full_init;
            tmr_en_reg    <= full_init;
            cmp_ref_reg   <= full_init;
            cmp_res_reg   <= full_init;
            int_lvl_reg   <= int_pin;
            port_clr_reg  <= full_init;
            tcnt_load_reg <= full_init;
            win_keep_reg  <= keep_ok;
            dmem_keep_reg <= keep_ok;
            sio_keep_reg  <= keep_ok;
            cause_reg     <= enter_init ? rsi_pkg::RSI_CAUSE_STACK :
                             !reset_pin_n ? rsi_pkg::RSI_CAUSE_PIN :
                                            rsi_pkg::RSI_CAUSE_PWR;
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic        access;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        wr_ctrl;
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    // one wait state: answer comes the cycle after the access phase opens
    assign access   = psel && penable && !pready_reg;
    assign hit_ctrl = (paddr == rsi_pkg::PDR_CTRL_OFS);
    assign hit_stat = (paddr == rsi_pkg::STATUS_OFS);
    assign wr_ctrl  = psel && penable && pready_reg && pwrite && hit_ctrl;

    // upper bits of each register read as zero
    assign rd_mux = hit_ctrl ? {31'h0000_0000, pdr_en_reg} :
                    hit_stat ? {26'h000_0000, cause_reg, state_reg} :
                               32'h0000_0000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= access;
            pslverr_reg <= access && !(hit_ctrl || hit_stat);
            prdata_reg  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // enable flag: every reset clears it, and a reset beats a write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pdr_en_reg <= rsi_pkg::PDR_CTRL_RST[rsi_pkg::PDR_EN_BIT];
        end else if (enter_any) begin
            pdr_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pdr_en_reg <= pwdata[rsi_pkg::PDR_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // output connections
    // ------------------------------------------------------------------
    assign prdata                       = prdata_reg;
    assign pready                       = pready_reg;
    assign pslverr                      = pslverr_reg;
    assign core_reset                   = core_reset_reg;
    assign sys_clock_run                = clk_run_reg;
    assign init_strobe                  = strobe_reg;
    // constant load values stand for flops folded at synthesis
    assign program_counter              = rsi_pkg::PC_START;
    assign timer_modulo                 = rsi_pkg::TMR_MOD_INIT;
    assign timer_count_init             = rsi_pkg::TMR_CNT_INIT;
    assign port_input_mode              = 1'b1;
    assign sysreg_clear                 = 1'b1;
    assign stack_pointer                = stk_ptr_reg;
    assign timer_interrupt_request_flag = tmr_irq_reg;
    assign timer_run_enable             = tmr_en_reg;
    assign comparator_reference_select  = cmp_ref_reg;
    assign comparator_result_bit        = cmp_res_reg;
    assign int_level                    = int_lvl_reg;
    assign power_down_reset_enable      = pdr_en_reg;
    assign port_latch_clear             = port_clr_reg;
    assign timer_count_load             = tcnt_load_reg;
    assign window_keep                  = win_keep_reg;
    assign data_memory_keep             = dmem_keep_reg;
    assign serial_shift_keep            = sio_keep_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_pdr_gated: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_reg == rsi_pkg::RSI_RUN && reset_pin_n && !power_on_det
         && power_down_det && !pdr_en_reg && !stack_fault)
        |=> state_reg == rsi_pkg::RSI_RUN)
        else $error("power-down reset taken while disabled");

    a_full_init_bits: assert property (
        @(posedge clk) disable iff (!reset_n)
        enter_hold |=> (stk_ptr_reg == 4'h5) && tmr_irq_reg && tmr_en_reg
                       && cmp_ref_reg && cmp_res_reg && !pdr_en_reg)
        else $error("level reset initial state wrong");

    a_int_level_copy: assert property (
        @(posedge clk) disable iff (!reset_n)
        enter_any |=> int_lvl_reg == $past(int_pin))
        else $error("interrupt level not captured");

    a_stack_init: assert property (
        @(posedge clk) disable iff (!reset_n)
        enter_init |=> (stk_ptr_reg == 4'h5) && !tmr_irq_reg && !tmr_en_reg
                       && !cmp_ref_reg && !port_clr_reg)
        else $error("stack fault initial state wrong");

    a_keep_standby: assert property (
        @(posedge clk) disable iff (!reset_n)
        enter_any |=> dmem_keep_reg == ($past(standby) && $past(level_req)))
        else $error("memory retention flag wrong");

    a_keep_all_same: assert property (
        @(posedge clk) disable iff (!reset_n)
        (win_keep_reg == sio_keep_reg) && (sio_keep_reg == dmem_keep_reg))
        else $error("retention flags disagree");

    a_stack_no_wait: assert property (
        @(posedge clk) disable iff (!reset_n)
        enter_init ##1 !level_req
        |=> state_reg == rsi_pkg::RSI_RUN && !core_reset_reg)
        else $error("stack fault reset did not skip wait");

    a_release_wait: assert property (
        @(posedge clk) disable iff (!reset_n)
        (reset_n && state_reg == rsi_pkg::RSI_HOLD && !level_req)
        |=> state_reg == rsi_pkg::RSI_WAIT && clk_run_reg && core_reset_reg)
        else $error("release did not start clock and wait");

    a_wait_length: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(state_reg == rsi_pkg::RSI_WAIT) && WAIT_CYCLES >= 8
        |-> !wait_done [*8])
        else $error("stabilisation wait ended too soon");

endmodule : rsi_reset_ctrl

// ---- logic/rsi_pkg.sv ----
package rsi_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PDR_CTRL_OFS  = 8'h10; // power_down_reset_control
    localparam logic [7:0] STATUS_OFS    = 8'h14; // reset cause and phase
    localparam int         PDR_EN_BIT    = 0;     // power_down_reset_enable
    localparam logic [3:0] PDR_CTRL_RST  = 4'h0;

    // ------------------------------------------------------------------
    // initial values applied by a reset
    // ------------------------------------------------------------------
    localparam int          PC_W          = 12;
    localparam logic [11:0] PC_START      = 12'h000;
    localparam logic [3:0]  SP_INIT       = 4'h5;
    localparam logic [7:0]  TMR_MOD_INIT  = 8'hFF;
    localparam logic [7:0]  TMR_CNT_INIT  = 8'h00;

    // ------------------------------------------------------------------
    // oscillation stabilisation wait: divide-by-256 clock counted to 256
    // ------------------------------------------------------------------
    localparam int STAB_DIV    = 256;
    localparam int STAB_COUNT  = 256;
    localparam int STAB_CYCLES = STAB_DIV * STAB_COUNT;
    localparam int STAB_W      = 17;

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RSI_RUN  = 4'b0001,
        RSI_HOLD = 4'b0010,
        RSI_WAIT = 4'b0100,
        RSI_INIT = 4'b1000
    } rsi_state_t;

    // reset causes, as kept in the status register
    typedef enum logic [1:0] {
        RSI_CAUSE_NONE  = 2'b00,
        RSI_CAUSE_PIN   = 2'b01,
        RSI_CAUSE_PWR   = 2'b10,
        RSI_CAUSE_STACK = 2'b11
    } rsi_cause_t;

endpackage : rsi_pkg

// ---- logic/rsi_stab_timer.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// stabilisation wait counter
// ----------------------------------------------------------------------
module rsi_stab_timer #(
    parameter int WAIT_CYCLES = rsi_pkg::STAB_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // control
    input  wire logic count_en,
    // status
    output logic      done
);

    logic [rsi_pkg::STAB_W-1:0] cnt_reg;
    logic [rsi_pkg::STAB_W-1:0] cnt_next;
    logic                       last;
    logic                       done_reg;

    // terminal count, constant cast down to the counter width STAB_W
    assign last     = (cnt_reg == rsi_pkg::STAB_W'(WAIT_CYCLES - 1));
    assign cnt_next = !count_en ? '0 :
                      last      ? cnt_reg :
                                  cnt_reg + 1'b1;

    // counter restarts whenever the wait phase is left
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= count_en && last && !done_reg;
        end
    end

    assign done = done_reg;

endmodule : rsi_stab_timer

// ---- dv/tb_reset_state_initializer.sv ----
`timescale 1ns/1ns
module tb_reset_state_initializer;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int W = 8; // short wait keeps the run brief
    logic        clk, reset_n, reset_pin_n, power_on_det, power_down_det;
    logic        stack_fault, standby, int_pin, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, core_reset, sys_clock_run, init_strobe;
    logic [11:0] program_counter;
    logic [3:0]  stack_pointer;
    logic        timer_interrupt_request_flag, timer_run_enable, er;
    logic        comparator_reference_select, comparator_result_bit;
    logic        int_level, power_down_reset_enable, port_input_mode;
    logic        port_latch_clear, timer_count_load, sysreg_clear;
    logic [7:0]  timer_count_init, timer_modulo;
    logic        window_keep, data_memory_keep, serial_shift_keep;
    int          n_errors, cmp_count, n;

    rsi_reset_ctrl #(.WAIT_CYCLES(W)) uut (
        .clk, .reset_n, .reset_pin_n, .power_on_det, .power_down_det,
        .stack_fault, .standby, .int_pin, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .core_reset,
        .sys_clock_run, .init_strobe, .program_counter, .stack_pointer,
        .timer_interrupt_request_flag, .timer_run_enable,
        .comparator_reference_select, .comparator_result_bit, .int_level,
        .power_down_reset_enable, .port_input_mode, .port_latch_clear,
        .timer_count_init, .timer_count_load, .timer_modulo, .sysreg_clear,
        .window_keep, .data_memory_keep, .serial_shift_keep
    );

    // ------------------------------------------------------------------
    // case table: source 0 pin, 1 power-on, 2 power-down, 3 stack
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] src;
        logic       stb;
        logic       ip;
        logic [3:0] ctl;  // flag, run enable, reference, result
        logic       lat;
        logic       keep;
    } rsi_row_t;
    rsi_row_t rows [8] = '{
        '{2'h0, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0},
        '{2'h0, 1'h1, 1'h1, 4'hF, 1'h1, 1'h1},
        '{2'h1, 1'h0, 1'h1, 4'hF, 1'h1, 1'h0},
        '{2'h1, 1'h1, 1'h0, 4'hF, 1'h1, 1'h1},
        '{2'h2, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0},
        '{2'h2, 1'h1, 1'h1, 4'hF, 1'h1, 1'h1},
        '{2'h3, 1'h0, 1'h1, 4'h0, 1'h0, 1'h0},
        '{2'h3, 1'h1, 1'h0, 4'h0, 1'h0, 1'h0}};

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) check(32'h0, 32'h1, "apb answer lost");
        if (i == 20) finish_test();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for the core to be let go
    task automatic wait_run(output int cnt);
        for (cnt = 0; cnt < W + 40; cnt++) begin
            @(posedge clk);
            if (core_reset === 1'b0) return;
        end
        check(32'h0, 32'h1, "core never released");
        finish_test();
    endtask : wait_run

    task automatic check_held;
        check(32'(core_reset), 32'h1, "core held");
        check(32'(sys_clock_run), 32'h0, "clock stopped");
        check(32'(stack_pointer), 32'h5, "stack pointer");
        check(32'(power_down_reset_enable), 32'h0, "enable");
        check(32'(pready), 32'h0, "pready idle");
    endtask : check_held

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0;
        cmp_count = 0;
        {reset_n, power_on_det, power_down_det, stack_fault} = 4'h0;
        {standby, int_pin, psel, penable, pwrite} = 5'h00;
        reset_pin_n = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge clk);
        check_held();
        reset_n <= 1'b1;
        // table of resets, each source with and without standby
        foreach (rows[r]) begin
            wait_run(n);
            if (rows[r].src == 2'h2) apb(1'b1, rsi_pkg::PDR_CTRL_OFS, 32'h1);
            @(posedge clk);
            standby <= rows[r].stb;
            int_pin <= rows[r].ip;
            case (rows[r].src)
                2'h0: reset_pin_n <= 1'b0;
                2'h1: power_on_det <= 1'b1;
                2'h2: power_down_det <= 1'b1;
                default: stack_fault <= 1'b1;
            endcase
            @(posedge clk);
            stack_fault <= 1'b0;
            @(posedge clk);
            check(32'(init_strobe), 32'h1, "strobe");
            check(32'(core_reset), 32'h1, "core held");
            check(32'(sys_clock_run), 32'(rows[r].src == 2'h3),
                  "clock");
            reset_pin_n <= 1'b1;
            power_on_det <= 1'b0;
            power_down_det <= 1'b0;
            wait_run(n);
            if (rows[r].src == 2'h3)
                check(32'(n <= 3), 32'h1, "no wait");
            else
                check(32'(n >= W - 1 && n <= W + 4), 32'h1, "wait");
            check(32'(stack_pointer), 32'h5, "stack");
            check(32'({timer_interrupt_request_flag, timer_run_enable,
                  comparator_reference_select, comparator_result_bit}),
                  32'(rows[r].ctl), "control bits");
            check(32'(int_level), 32'(rows[r].ip), "int level");
            check(32'(port_latch_clear), 32'(rows[r].lat), "latch");
            check(32'(timer_count_load), 32'(rows[r].lat), "count");
            check(32'(window_keep), 32'(rows[r].keep), "window");
            check(32'(data_memory_keep), 32'(rows[r].keep), "mem");
            check(32'(serial_shift_keep), 32'(rows[r].keep), "sio");
            check(32'(program_counter), 32'h0, "pc");
            check(32'(timer_modulo), 32'h0000_00FF, "modulo");
            check(32'(timer_count_init), 32'h0, "count init");
            check(32'({port_input_mode, sysreg_clear, sys_clock_run}),
                  32'h7, "modes");
            standby <= 1'b0;
            int_pin <= 1'b0;
            apb(1'b0, rsi_pkg::STATUS_OFS, 32'h0);
            n = (rows[r].src == 2'h0) ? 1 : (rows[r].src == 2'h3) ? 3 : 2;
            check(rd, 32'(n * 16 + 1), "status cause");
            apb(1'b0, rsi_pkg::PDR_CTRL_OFS, 32'h0);
            check(rd, 32'h0, "enable cleared");
            $display("row %0d done", r);
        end
        // detector without enable must not reset
        @(posedge clk);
        power_down_det <= 1'b1;
        repeat (4) begin
            @(posedge clk);
            check(32'({core_reset, init_strobe}), 32'h0, "quiet");
        end
        power_down_det <= 1'b0;
        $display("disabled detector test done");
        // register access, read-only status and an unmapped place
        apb(1'b1, rsi_pkg::PDR_CTRL_OFS, 32'hFFFF_FFFF);
        apb(1'b0, rsi_pkg::PDR_CTRL_OFS, 32'h0);
        check(rd, 32'h0000_0001, "enable bit only");
        apb(1'b1, rsi_pkg::STATUS_OFS, 32'h0000_00FF);
        check(32'(er), 32'h0, "status write error");
        apb(1'b0, rsi_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h0000_0031, "status kept");
        apb(1'b0, 8'h20, 32'h0);
        check({rd[30:0], er}, 32'h1, "unmapped read");
        $display("register test done");
        // stack fault during the wait is refused
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (2) @(posedge clk);
        stack_fault <= 1'b1;
        @(posedge clk);
        stack_fault <= 1'b0;
        wait_run(n);
        check(32'(n >= W - 3), 32'h1, "wait not cut short");
        apb(1'b0, rsi_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h0000_0011, "cause pin");
        $display("stack during wait test done");
        // second reset in mid-run
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check_held();
        reset_n <= 1'b1;
        wait_run(n);
        check(32'(n >= W - 1), 32'h1, "wait after reset");
        $display("mid-run reset test done");
        finish_test();
    end

endmodule : tb_reset_state_initializer
